// ### beacon_pulse_simulator.sv
/*
 * beacon_pulse_simulator: timing core of a navigation beacon simulator.
 * assumes interrogation video and the sensitivity selector arrive from pins
 * asynchronous to clk; the reference timebase is derived from clk.
 */
`timescale 1ns/1ns

// Contract
// RULE1: interrogator sends pairs spaced 12 us plus or minus 0.5 us.
// RULE2: interrogator repeats 24-30 pairs/s tracking, 120-150 searching.
// RULE3: each received interrogation pair gives exactly one decoded pulse.
// RULE4: decoded pulse delayed by 5 or 105 mile range per select input.
// RULE5: identity pulses are pairs 100 us apart, one pair per 1350 Hz period.
// RULE6: identity stream runs continuously, never keyed or coded.
// RULE7: range replies and identity pulses merge into lowest-priority stream.
// RULE8: reference divided by ten gives 135 Hz harmonic trigger.
// RULE9: 135 Hz trigger divided by nine gives 15 Hz trigger.
// RULE10: each 15 Hz trigger starts one north marker burst.
// RULE11: harmonic burst is six pulses 24 us apart.
// RULE12: north burst is twelve pulses 30 us apart.
// RULE13: a running burst blanks every lower-priority stream throughout.
// RULE14: priority is north, then harmonic, then reply plus identity.
// RULE15: every gated pulse becomes a fixed-width pair 12 us apart. Here a gated pulse within 12 us of the last drops that one's second pulse.
// RULE16: power-measure position routes input to power path, not decoder.
// RULE17: sensitivity position makes the device the coded signal generator.
// RULE18: all timing comes from counters on one parameterised clock.
// RULE19: reset clears dividers, bursts, range delay; silent until next period. Here only identity and bursts wait; replies go out at once.
// RULE20: interrogations arriving during a pending range delay are ignored.
module beacon_pulse_simulator #(
    parameter int CLK_FREQ = beacon_pkg::CLK_HZ
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // pins from the airborne set
    input wire logic interrog_in,
    // front panel selectors
    input wire logic sensitivity_generator_position,
    input wire logic range_long,
    // outputs
    output logic video_out,
    output logic power_path_out,
    output beacon_pkg::streams_t streams
);
    import beacon_pkg::*;

    if (CLK_FREQ != CLK_HZ) begin : g_bad_clk
        $error("clock must match package timing constants");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] irq_s_q, sens_s_q, rng_s_q;
    logic in_prev_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irq_s_q <= '0;
            sens_s_q <= '0;
            rng_s_q <= '0;
            in_prev_q <= 1'b0;
        end else begin
            irq_s_q <= {irq_s_q[0], interrog_in};
            sens_s_q <= {sens_s_q[0], sensitivity_generator_position};
            rng_s_q <= {rng_s_q[0], range_long};
            in_prev_q <= irq_s_q[1];
        end
    end
    wire gen_mode = sens_s_q[1];
    // power-measure position sends the input to the power path only [RULE16]
    assign power_path_out = !gen_mode && irq_s_q[1];
    wire dec_in = gen_mode && irq_s_q[1];
    wire in_rise = dec_in && !in_prev_q;

    // ------------------------------------------------------------
    // pair decoder and range delay
    // ------------------------------------------------------------
    dec_state_t st_q;
    logic [CW-1:0] dcnt_q;
    logic reply_q;
    wire pair_ok = (dcnt_q >= CW'(PAIR_CYC - TOL_CYC)) && (dcnt_q <= CW'(PAIR_CYC + TOL_CYC));
    wire [CW-1:0] delay_cyc = rng_s_q[1] ? CW'(LONG_CYC) : CW'(SHORT_CYC);
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q <= DEC_IDLE;
            dcnt_q <= '0;
            reply_q <= 1'b0;
        end else begin
            reply_q <= 1'b0;
            case (st_q)
                DEC_IDLE: begin
                    dcnt_q <= '0;
                    if (in_rise) st_q <= DEC_WAIT;
                end
                DEC_WAIT: begin
                    dcnt_q <= dcnt_q + CW'(1);
                    // second pulse inside the window yields one decoded pulse [RULE3] [RULE1]
                    if (in_rise && pair_ok) begin
                        st_q <= DEC_HOLD;
                        dcnt_q <= delay_cyc;
                    end else if (dcnt_q > CW'(PAIR_CYC + TOL_CYC)) begin
                        st_q <= DEC_IDLE;
                    end
                end
                DEC_HOLD: begin
                    // new interrogations ignored while the reply is pending [RULE20]
                    dcnt_q <= dcnt_q - CW'(1);
                    if (dcnt_q == CW'(1)) begin
                        reply_q <= 1'b1; // range delay [RULE4]
                        st_q <= DEC_IDLE;
                    end
                end
                default: st_q <= DEC_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // reference, identity and dividers
    // ------------------------------------------------------------
    logic [CW-1:0] ref_q;
    logic [3:0] div10_q, div9_q;
    logic armed_q, ident_q, ref_tick_q;
    wire ref_tick = (ref_q == CW'(REF_CYC - 1)); // counter timebase [RULE18]
    wire tick135 = ref_tick && div10_q == 4'(HARM_DIV - 1);
    wire tick15 = tick135 && div9_q == 4'(NORTH_DIV - 1);
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ref_q <= '0;
            div10_q <= '0;
            div9_q <= '0;
            armed_q <= 1'b0;
            ident_q <= 1'b0;
            ref_tick_q <= 1'b0;
        end else begin
            ref_q <= ref_tick ? '0 : ref_q + CW'(1);
            ref_tick_q <= ref_tick;
            if (ref_tick) armed_q <= 1'b1; // identity and bursts silent until next period; replies not held off [RULE19]
            if (ref_tick) div10_q <= (div10_q == 4'(HARM_DIV - 1)) ? 4'h0 : div10_q + 4'h1; // [RULE8]
            if (tick135) div9_q <= (div9_q == 4'(NORTH_DIV - 1)) ? 4'h0 : div9_q + 4'h1; // [RULE9]
            // free-running identity pair, never keyed [RULE5] [RULE6]
            ident_q <= armed_q && (ref_q == CW'(0) || ref_q == CW'(IDENT_CYC));
        end
    end

    // ------------------------------------------------------------
    // marker bursts
    // ------------------------------------------------------------
    logic harm_p, harm_b, north_p, north_b;
    burst_gen #(.PULSES(HARM_PULSES), .SPACING(HARM_CYC)) u_harm ( // [RULE11]
        .clk(clk), .rstn(rstn), .trig(tick135 && armed_q), .pulse(harm_p), .blank(harm_b));
    burst_gen #(.PULSES(NORTH_PULSES), .SPACING(NORTH_CYC)) u_north ( // [RULE12] [RULE10]
        .clk(clk), .rstn(rstn), .trig(tick15 && armed_q), .pulse(north_p), .blank(north_b));

    // ------------------------------------------------------------
    // priority gate and pair coder
    // ------------------------------------------------------------
    wire low_stream = reply_q || ident_q; // [RULE7]
    // blanking keeps lower streams off for whole bursts [RULE13] [RULE14]
    wire gated = north_p || (harm_p && !north_b) || (low_stream && !north_b && !harm_b);

    logic [CW-1:0] pair_q;
    logic [CW-1:0] wid_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pair_q <= '0;
            wid_q <= '0;
        end else begin
            // second pulse follows the last gated pulse exactly PAIR_CYC later; a newer one restarts the count [RULE15]
            if (gated && gen_mode) pair_q <= CW'(PAIR_CYC);
            else if (pair_q != '0) pair_q <= pair_q - CW'(1);
            if ((gated && gen_mode) || pair_q == CW'(1)) wid_q <= CW'(PULSE_CYC);
            else if (wid_q != '0) wid_q <= wid_q - CW'(1);
        end
    end
    // pairs start only in generator position; a second pulse already pending still goes out after a switch [RULE17]
    assign video_out = (wid_q != '0);
    assign streams = '{ident: ident_q, reply: reply_q, harm: harm_p, north: north_p,
                       blank_harm: harm_b, blank_north: north_b};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // ages since the last gated pulse and the last identity pulse; both
    // spacings are too long for a plain delay
    logic [CW-1:0] gate_age_q;
    logic [CW-1:0] id_gap_q;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            gate_age_q <= '1;
            id_gap_q <= '1;
        end else begin
            if (gated && gen_mode) gate_age_q <= CW'(1);
            else if (gate_age_q != '1) gate_age_q <= gate_age_q + CW'(1);
            if (ident_q) id_gap_q <= CW'(1);
            else if (id_gap_q != '1) id_gap_q <= id_gap_q + CW'(1);
        end
    end

    sequence s_ident_second;
        ident_q && ref_q == CW'(IDENT_CYC + 1);
    endsequence
    property p_ident;
        @(posedge clk) disable iff (!rstn) s_ident_second |-> id_gap_q == CW'(IDENT_CYC);
    endproperty
    a_ident: assert property (p_ident) else $error("identity pair spacing wrong"); // [RULE5]

    property p_blank;
        @(posedge clk) disable iff (!rstn) north_b |-> !(harm_p && gated && !north_p);
    endproperty
    a_blank: assert property (p_blank) else $error("harmonic leaked under north blank"); // [RULE13]

    property p_low_blank;
        @(posedge clk) disable iff (!rstn) (harm_b || north_b) && gated |-> (harm_p || north_p);
    endproperty
    a_low_blank: assert property (p_low_blank) else $error("low stream leaked"); // [RULE14]

    property p_pair;
        @(posedge clk) disable iff (!rstn) gate_age_q == CW'(PAIR_CYC + 1) |-> video_out;
    endproperty
    a_pair: assert property (p_pair) else $error("second pulse of pair missing"); // [RULE15]

    property p_div15;
        @(posedge clk) disable iff (!rstn) tick15 |-> tick135 && div10_q == 4'(HARM_DIV - 1);
    endproperty
    a_div15: assert property (p_div15) else $error("15 Hz trigger off the 135 Hz grid"); // [RULE9]

    property p_hold;
        @(posedge clk) disable iff (!rstn) (st_q == DEC_HOLD && dcnt_q > CW'(1)) |=> st_q == DEC_HOLD;
    endproperty
    a_hold: assert property (p_hold) else $error("pending reply abandoned"); // [RULE20]

    property p_power;
        @(posedge clk) disable iff (!rstn) !gen_mode |-> !dec_in;
    endproperty
    a_power: assert property (p_power) else $error("decoder fed in power position"); // [RULE16]

    property p_reply_once;
        @(posedge clk) disable iff (!rstn) reply_q |=> !reply_q;
    endproperty
    a_reply_once: assert property (p_reply_once) else $error("reply repeated"); // [RULE3]
endmodule : beacon_pulse_simulator

// ### beacon_pkg.sv
/*
 * beacon_pkg: constants and carrier types for the beacon pulse simulator.
 * assumes a single synchronous system clock at CLK_HZ.
 */
package beacon_pkg;
    // ------------------------------------------------------------
    // clock and times
    // ------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int REF_HZ = 1350;
    localparam int PAIR_SPACING_US = 12;
    localparam int IDENT_SPACING_US = 100;
    localparam int HARM_SPACING_US = 24;
    localparam int NORTH_SPACING_US = 30;
    localparam int PAIR_TOL_NS = 500;
    localparam int RANGE_SHORT_MILES = 5;
    localparam int RANGE_LONG_MILES = 105;
    // one radar mile round trip, in ns (12.36 us)
    localparam int NS_PER_MILE = 12360;
    localparam int PULSE_NS = 3500;
    // ------------------------------------------------------------
    // counts and ratios
    // ------------------------------------------------------------
    localparam int HARM_DIV = 10;
    localparam int NORTH_DIV = 9;
    localparam int HARM_PULSES = 6;
    localparam int NORTH_PULSES = 12;
    localparam int PULSE_CYC = (PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int PAIR_CYC = PAIR_SPACING_US * (CLK_HZ / 1_000_000);
    localparam int TOL_CYC = PAIR_TOL_NS * (CLK_HZ / 1_000_000) / 1000;
    localparam int IDENT_CYC = IDENT_SPACING_US * (CLK_HZ / 1_000_000);
    localparam int HARM_CYC = HARM_SPACING_US * (CLK_HZ / 1_000_000);
    localparam int NORTH_CYC = NORTH_SPACING_US * (CLK_HZ / 1_000_000);
    localparam int REF_CYC = CLK_HZ / REF_HZ;
    localparam int SHORT_CYC = RANGE_SHORT_MILES * NS_PER_MILE / 1000 * (CLK_HZ / 1_000_000);
    localparam int LONG_CYC = RANGE_LONG_MILES * NS_PER_MILE / 1000 * (CLK_HZ / 1_000_000);
    localparam int CW = 24;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic ident;
        logic reply;
        logic harm;
        logic north;
        logic blank_harm;
        logic blank_north;
    } streams_t;

    typedef enum logic [2:0] {
        DEC_IDLE = 3'b001,
        DEC_WAIT = 3'b010,
        DEC_HOLD = 3'b100
    } dec_state_t;
endpackage : beacon_pkg

// ### burst_gen.sv
/*
 * burst_gen: marker burst of N single-cycle pulses at fixed spacing,
 * with a blanking level held for the whole burst.
 * assumes trig is a one-cycle pulse on clk.
 */
`timescale 1ns/1ns
module burst_gen #(
    parameter int PULSES = 6,
    parameter int SPACING = 3000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic trig,
    // outputs
    output logic pulse,
    output logic blank
);
    import beacon_pkg::*;

    // left_q is eight bits wide and the spacing counter CW bits wide
    if (PULSES < 1 || PULSES > 255 || SPACING < 2 || SPACING > 1000000) begin : g_bad_params
        $error("burst_gen: bad parameters");
    end

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] gap_q;
    logic [7:0] left_q;
    logic pulse_q;
    wire fire = blank && (cnt_q == CW'(0));

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_q <= '0;
            left_q <= '0;
            pulse_q <= 1'b0;
        end else if (trig && left_q == 8'h00) begin
            cnt_q <= '0;
            left_q <= 8'(PULSES);
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= fire;
            if (fire) begin
                left_q <= left_q - 8'h01;
                cnt_q <= CW'(SPACING - 1);
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - CW'(1);
            end
        end
    end

    // blank covers the burst until the last pulse has gone out
    assign blank = (left_q != 8'h00) || pulse_q;
    assign pulse = pulse_q;

    // age of the last pulse; spacing is far beyond a plain delay, so count it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            gap_q <= '1;
        end else if (pulse_q) begin
            gap_q <= CW'(1);
        end else if (gap_q != '1) begin
            gap_q <= gap_q + CW'(1);
        end
    end

    property p_burst_spacing;
        @(posedge clk) disable iff (!rstn)
            (pulse && left_q != 8'(PULSES - 1)) |-> gap_q == CW'(SPACING);
    endproperty
    a_burst_spacing: assert property (p_burst_spacing) else $error("burst spacing wrong");
endmodule : burst_gen

// ### interrogator_model.sv
/*
 * interrogator_model: airborne interrogator, one pulse pair per request.
 * assumes fire is a one-cycle request on clk and gap is given in clk cycles.
 */
`timescale 1ns/1ns
module interrogator_model #(
    parameter int WIDTH = 438
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // command from the bench
    input wire logic fire,
    input wire logic [15:0] gap,
    // line to the device, busy flag to the bench
    output logic video,
    output logic busy
);
    logic [15:0] cnt_q;
    logic [15:0] gap_q;

    // ------------------------------------------------------------
    // pair timing
    // ------------------------------------------------------------
    // video line is driven low between pulses, never left floating
    assign video = busy && (cnt_q < WIDTH || (cnt_q >= gap_q && cnt_q < gap_q + WIDTH));

    always_ff @(posedge clk) begin
        if (!rstn) begin
            busy <= 1'b0;
            cnt_q <= 16'h0;
            gap_q <= 16'h0;
        end else if (fire && !busy) begin
            busy <= 1'b1;
            cnt_q <= 16'h0;
            gap_q <= gap;
        end else if (busy) begin
            cnt_q <= cnt_q + 16'h1;
            busy <= (32'(cnt_q) + 1 < 32'(gap_q) + WIDTH);
        end
    end
endmodule : interrogator_model

// ### beacon_pulse_simulator_bench.sv
/*
 * beacon_pulse_simulator_bench: self-checking bench for the beacon core.
 * assumes the package clock of 125 MHz; long bursts lie beyond the run.
 */
`timescale 1ns/1ns
module beacon_pulse_simulator_bench;
    import beacon_pkg::*;
    logic clk;
    logic rstn;
    logic fire;
    logic [15:0] gap;
    logic sens;
    logic range_long;
    logic interrog;
    logic busy;
    logic video_out;
    logic power_path_out;
    logic in_prev = 1'b0;
    logic v_prev = 1'b0;
    int pp_cnt = 0;
    logic harm_seen = 1'b0;
    streams_t streams;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    int rel = 0;
    int in_at = 0;
    int rep_cnt = 0;
    int rep_at = 0;
    int vr[$];
    int vw[$];
    int iq[$];

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    beacon_pulse_simulator u_beacon_pulse_simulator (.clk(clk), .rstn(rstn),
        .interrog_in(interrog), .sensitivity_generator_position(sens),
        .range_long(range_long), .video_out(video_out),
        .power_path_out(power_path_out), .streams(streams));

    interrogator_model u_interrogator_model (.clk(clk), .rstn(rstn), .fire(fire),
        .gap(gap), .video(interrog), .busy(busy));

    // ------------------------------------------------------------
    // monitor and timeout
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        in_prev <= interrog;
        v_prev <= (video_out === 1'b1);
        if (interrog && !in_prev)
            in_at <= cyc;
        if (streams.reply === 1'b1) begin
            rep_cnt <= rep_cnt + 1;
            rep_at <= cyc;
        end
        if (video_out === 1'b1 && !v_prev)
            vr.push_back(cyc);
        if (video_out !== 1'b1 && v_prev)
            vw.push_back(cyc - vr[$]);
        if (streams.ident === 1'b1)
            iq.push_back(cyc);
        if (power_path_out === 1'b1)
            pp_cnt <= pp_cnt + 1;
        if (streams.harm !== 1'b0 || streams.north !== 1'b0 || streams.blank_harm !== 1'b0)
            harm_seen <= 1'b1;
        // second identity pulse lands near 105000 cycles after release
        if (cyc == 110000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic end_of_test();
        if (error_cnt == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    // pairs come far faster than a real set repeats; the next pair may fall inside a pending range delay
    task automatic send(input int g);
        int n;
        n = 0;
        gap <= g[15:0];
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        @(posedge clk);
        while (busy !== 1'b0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
    endtask : send

    task automatic no_reply(input string what);
        int c;
        c = rep_cnt;
        send(PAIR_CYC);
        repeat (SHORT_CYC + 300) @(posedge clk);
        chk(what, rep_cnt - c, 0);
    endtask : no_reply

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reply();
        int c;
        int in2;
        int n;
        int p;
        c = rep_cnt;
        p = pp_cnt;
        send(PAIR_CYC);
        in2 = in_at;
        send(PAIR_CYC);
        repeat (SHORT_CYC + PAIR_CYC + 3000) @(posedge clk);
        chk("reply count", rep_cnt - c, 1);
        chk("reply delay", (rep_at - in2 >= SHORT_CYC && rep_at - in2 <= SHORT_CYC + 5), 1);
        chk("power path quiet", pp_cnt - p, 0);
        n = vr.size();
        chk("video pulses", (n >= 2), 1);
        if (n >= 2) begin
            chk("video start", vr[n - 2] - rep_at, 1);
            chk("video spacing", vr[n - 1] - vr[n - 2], PAIR_CYC);
            chk("video width", vw[$], PULSE_CYC);
        end
    endtask : t_reply

    task automatic t_bad_spacing();
        int c;
        c = rep_cnt;
        send(PAIR_CYC + TOL_CYC + 40);
        repeat (SHORT_CYC + 300) @(posedge clk);
        chk("bad spacing reply", rep_cnt - c, 0);
    endtask : t_bad_spacing

    task automatic t_ident();
        int n;
        int hit;
        n = 0;
        hit = 0;
        while (iq.size() < 2 && n < 100000) begin
            @(posedge clk);
            n++;
        end
        repeat (PAIR_CYC + PULSE_CYC + 10) @(posedge clk);
        chk("ident pair", (iq.size() >= 2), 1);
        if (iq.size() >= 2) begin
            chk("ident spacing", iq[1] - iq[0], IDENT_CYC);
            chk("first ident", (iq[0] - rel >= REF_CYC - 4 && iq[0] - rel <= REF_CYC + 4), 1);
            foreach (vr[i])
                if (vr[i] == iq[0] + 1)
                    hit = 1;
            chk("ident on video", hit, 1);
        end
        chk("no marker yet", harm_seen, 1'b0);
    endtask : t_ident

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        fire = 1'b0;
        gap = 16'h0;
        sens = 1'b0;
        range_long = 1'b0;
        repeat (10) @(posedge clk);
        chk("video in reset", video_out, 1'b0);
        chk("streams in reset", {26'h0, streams}, 32'h0);
        rstn <= 1'b1;
        rel = cyc;
        repeat (5) @(posedge clk);
        no_reply("measure mode reply");
        chk("power path", (pp_cnt > 0), 1);
        sens <= 1'b1;
        repeat (5) @(posedge clk);
        t_bad_spacing();
        t_reply();
        range_long <= 1'b1;
        repeat (5) @(posedge clk);
        no_reply("long range early reply");
        t_ident();
        end_of_test();
    end
endmodule : beacon_pulse_simulator_bench
